// *** src/cmbc_dev.sv ***
// Message buffer controller: buffer registers, transmit queue and receive loading
// Behaviour
// [RQ1] Matching remote request auto-queues armed transmit buffer
// [RQ2] Pending buffer ignores register writes
// [RQ3] Firmware arms direction, filter, auto-reply, data
// [RQ4] Firmware loads buffer only while request clear
// [RQ5] Setting request clears abort, arbitration, error flags
// [RQ6] Send starts on idle bus, best buffer
// [RQ7] Success clears request, sets done flag, irq
// [RQ8] Failure keeps request; sets error or arbitration flag
// [RQ9] Firmware aborts one buffer by clearing request
// [RQ10] Abort-all bit aborts every pending buffer
// [RQ11] Abort acts on idle or failed message, flags it
// [RQ12] Running message completes; failure then aborts it
// [RQ13] Only hardware or reset clears abort requests
// [RQ14] Highest priority first, ties to highest number
// [RQ15] Priority 11 highest, 00 lowest
// [RQ16] Accepted frame overwrites whole receive buffer
// [RQ17] Load sets full flag, locks until cleared
// [RQ18] Record filter hit and remote flag
// [RQ19] Identifier type bit in std_ident_low
// [RQ20] Receive modes limit identifier type; in enhanced mode the code uses rx_mask_ext_en instead
// [RQ21] Mode 11 accepts all, keeps partial frames
// [RQ22] Frames aimed at transmit buffers are discarded
// [RQ23] Buffers reset to receive direction
`timescale 1ns/1ps
module cmbc_dev
  import cmbc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  cmbc_if.dev bus,
  input wire logic bus_idle,
  input wire logic tx_ok,
  input wire logic tx_arb_lost,
  input wire logic tx_error,
  input wire logic rx_valid,
  input wire logic [2:0] rx_target,
  input wire cmbc_frame_t rx_frame,
  input wire logic rx_ext,
  input wire logic rx_rtr,
  input wire logic rx_error,
  input wire logic rx_match,
  input wire logic rx_filter_ext,
  input wire logic rx_mask_ext_en,
  input wire logic [4:0] rx_hit,
  output logic tx_start,
  output logic [2:0] tx_idx,
  output cmbc_frame_t tx_frame
);
  typedef enum logic {DEV_IDLE, DEV_SEND} cmbc_dev_st_t;

  typedef struct packed {
    logic [NBUF-1:0][NREG-1:0][7:0] mem; // Buffer registers
    logic [NBUF-1:0] dir; // Direction, 1 = transmit
    logic [NBUF-1:0] abort_pend; // Abort requested, not yet processed
    logic [NBUF-1:0] txif; // Transmit done flags
    logic [NBUF-1:0] txie; // Transmit done enables
    logic abort_all; // Abort-all request
    logic enh; // Enhanced mode
    logic buserr; // Bus error flag
    logic buserr_ie;
    logic rxie;
    cmbc_dev_st_t st;
    logic [2:0] cur; // Buffer on the bus
    logic tx_start;
    logic [2:0] tx_idx;
    cmbc_frame_t tx_frame;
    logic [7:0] rdata;
    logic rd_valid;
    logic irq;
  } cmbc_dev_state_t;

  cmbc_dev_state_t s_reg; // Registered state
  cmbc_dev_state_t s_next; // Next state
  logic [NBUF-1:0] ready; // Buffers eligible for arbitration
  logic [NBUF-1:0][1:0] prio; // Their priority fields
  logic pick_valid;
  logic [2:0] pick_idx;
  logic [2:0] bi; // Addressed page
  logic [3:0] ri; // Addressed register
  logic [1:0] receive_mode_select; // Mode of the receive target
  logic type_ok; // Identifier type allowed
  logic accept; // Frame passes acceptance; loaded only if not full

  assign bi = bus.addr[6:4];
  assign ri = bus.addr[3:0];

  // Pending, not being aborted, transmit direction
  always_comb begin
    for (int i = 0; i < NBUF; i++) begin
      ready[i] = s_reg.dir[i] && s_reg.mem[i][REG_CTRL][CTL_SEND] && !s_reg.abort_pend[i];
      prio[i] = s_reg.mem[i][REG_CTRL][CTL_PRI +: 2];
    end
  end

  cmbc_prio_pick u_pick (
    .ready(ready),
    .prio(prio),
    .valid(pick_valid),
    .idx(pick_idx)
  );

  // Next-state logic; hardware events come after firmware writes so a set beats a clear
  always_comb begin
    s_next = s_reg;
    s_next.tx_start = 1'b0;
    s_next.rd_valid = bus.rd_en;
    receive_mode_select = 2'h0;
    type_ok = 1'b0;
    accept = 1'b0;
    // Firmware writes
    if (bus.wr_en) begin
      if (bi == PAGE_GLOBAL) begin
        case (ri)
          GREG_MCR: begin
            s_next.enh = bus.wdata[MCR_ENH];
            if (bus.wdata[MCR_ABORT_ALL]) s_next.abort_all = 1'b1; // [RQ10] [RQ13]
          end
          GREG_BSEL: s_next.dir = bus.wdata[NBUF-1:0];
          GREG_TXIF: s_next.txif = s_reg.txif & ~bus.wdata[NBUF-1:0];
          GREG_TXIE: s_next.txie = bus.wdata[NBUF-1:0];
          GREG_MISC: begin
            if (bus.wdata[MISC_BUSERR]) s_next.buserr = 1'b0;
            s_next.buserr_ie = bus.wdata[MISC_BUSERR_IE];
            s_next.rxie = bus.wdata[MISC_RXIE];
          end
          default: ; // Unmapped: ignored
        endcase
      end else if (int'(bi) < NBUF && ri <= REG_LAST) begin
        if (s_reg.dir[bi] && s_reg.mem[bi][REG_CTRL][CTL_SEND]) begin
          // Locked; the only effect is an abort request by clearing send_request
          if (ri == REG_CTRL && !bus.wdata[CTL_SEND]) begin
            s_next.abort_pend[bi] = 1'b1; // [RQ2] [RQ9]
          end
        end else if (s_reg.dir[bi] && ri == REG_CTRL) begin
          s_next.mem[bi][REG_CTRL][CTL_PRI +: 2] = bus.wdata[CTL_PRI +: 2];
          s_next.mem[bi][REG_CTRL][CTL_AUTO] = bus.wdata[CTL_AUTO];
          if (bus.wdata[CTL_SEND]) begin
            s_next.mem[bi][REG_CTRL][CTL_SEND] = 1'b1;
            s_next.mem[bi][REG_CTRL][CTL_ABORT] = 1'b0; // [RQ5]
            s_next.mem[bi][REG_CTRL][CTL_ARBL] = 1'b0; // [RQ5]
            s_next.mem[bi][REG_CTRL][CTL_TRANSMIT_ERROR_FLAG] = 1'b0; // [RQ5]
          end
        end else if (!s_reg.dir[bi] && ri == REG_CTRL) begin
          s_next.mem[bi][REG_CTRL][CTL_RXM +: 2] = bus.wdata[CTL_RXM +: 2];
          if (!bus.wdata[CTL_FULL]) s_next.mem[bi][REG_CTRL][CTL_FULL] = 1'b0; // [RQ17]
        end else begin
          s_next.mem[bi][ri] = bus.wdata;
        end
      end
    end
    // Abort-all marks every pending transmit buffer, then clears itself
    if (s_reg.abort_all) begin
      for (int i = 0; i < NBUF; i++) begin
        if (ready[i]) s_next.abort_pend[i] = 1'b1; // [RQ10]
      end
      s_next.abort_all = 1'b0; // [RQ13]
    end
    // Abort of a message not on the bus is processed at once
    for (int i = 0; i < NBUF; i++) begin
      if (s_reg.abort_pend[i] && !(s_reg.st == DEV_SEND && int'(s_reg.cur) == i)) begin
        s_next.abort_pend[i] = 1'b0; // [RQ13]
        s_next.mem[i][REG_CTRL][CTL_SEND] = 1'b0;
        s_next.mem[i][REG_CTRL][CTL_ABORT] = 1'b1; // [RQ11]
      end
    end
    // Transmit sequencing
    case (s_reg.st)
      DEV_IDLE: begin
        if (bus_idle && pick_valid) begin // [RQ6]
          s_next.st = DEV_SEND;
          s_next.cur = pick_idx;
          s_next.tx_start = 1'b1;
          s_next.tx_idx = pick_idx;
          for (int k = 0; k < FRAME_BYTES; k++) s_next.tx_frame[k] = s_reg.mem[pick_idx][k + 1];
        end
      end
      DEV_SEND: begin
        if (tx_ok) begin
          s_next.st = DEV_IDLE;
          s_next.mem[s_reg.cur][REG_CTRL][CTL_SEND] = 1'b0; // [RQ7]
          s_next.txif[s_reg.cur] = 1'b1; // [RQ7] [RQ12]
          s_next.abort_pend[s_reg.cur] = 1'b0;
        end else if (tx_arb_lost || tx_error) begin
          s_next.st = DEV_IDLE;
          if (tx_error) begin
            s_next.mem[s_reg.cur][REG_CTRL][CTL_TRANSMIT_ERROR_FLAG] = 1'b1; // [RQ8]
            s_next.buserr = 1'b1; // [RQ8]
          end else begin
            s_next.mem[s_reg.cur][REG_CTRL][CTL_ARBL] = 1'b1; // [RQ8]
          end
          // Failed message with an abort pending is not retried
          if (s_reg.abort_pend[s_reg.cur]) begin
            s_next.abort_pend[s_reg.cur] = 1'b0;
            s_next.mem[s_reg.cur][REG_CTRL][CTL_SEND] = 1'b0; // [RQ12]
            s_next.mem[s_reg.cur][REG_CTRL][CTL_ABORT] = 1'b1; // [RQ12]
          end
        end
      end
      default: s_next.st = DEV_IDLE;
    endcase
    // Reception; checks use s_next so a clear in this cycle lets the frame in
    if (rx_valid && int'(rx_target) < NBUF) begin
      if (s_reg.dir[rx_target]) begin // Transmit target: only an armed reply acts
        if (rx_rtr && !rx_error && rx_match && s_next.mem[rx_target][REG_CTRL][CTL_AUTO]
            && !s_next.mem[rx_target][REG_CTRL][CTL_SEND]) begin // [RQ22]
          s_next.mem[rx_target][REG_CTRL][CTL_SEND] = 1'b1; // [RQ1]
          s_next.mem[rx_target][REG_CTRL][CTL_ABORT] = 1'b0; // [RQ5]
          s_next.mem[rx_target][REG_CTRL][CTL_ARBL] = 1'b0;
          s_next.mem[rx_target][REG_CTRL][CTL_TRANSMIT_ERROR_FLAG] = 1'b0;
        end
      end else begin
        receive_mode_select = s_next.mem[rx_target][REG_CTRL][CTL_RXM +: 2];
        if (s_reg.enh) begin
          type_ok = !rx_mask_ext_en || (rx_ext == rx_filter_ext); // [RQ20]
          accept = receive_mode_select[1] || (rx_match && !rx_error && type_ok); // [RQ21]
        end else begin
          case (receive_mode_select)
            RXM_FILTERED: type_ok = (rx_ext == rx_filter_ext); // [RQ20]
            RXM_STD_ONLY: type_ok = !rx_ext; // [RQ20]
            RXM_EXT_ONLY: type_ok = rx_ext; // [RQ20]
            default: type_ok = 1'b1;
          endcase
          accept = (receive_mode_select == RXM_ANY) || (rx_match && !rx_error && type_ok); // [RQ21]
        end
        if (accept && !s_next.mem[rx_target][REG_CTRL][CTL_FULL]) begin // [RQ17]
          for (int k = 0; k < FRAME_BYTES; k++) begin
            s_next.mem[rx_target][k + 1] = rx_frame[k]; // [RQ16]
          end
          s_next.mem[rx_target][REG_STD_IDENT_LOW][STD_IDENT_LOW_EXT] = rx_ext; // [RQ19]
          s_next.mem[rx_target][REG_CTRL][CTL_FULL] = 1'b1; // [RQ17]
          s_next.mem[rx_target][REG_CTRL][CTL_HIT +: 5] =
            s_reg.enh ? rx_hit : {1'b0, rx_hit[3:0]}; // [RQ18]
          s_next.mem[rx_target][REG_RXSTAT] = {7'h00, rx_rtr}; // [RQ18]
        end
      end
    end
    if (bus.rd_en) begin // Read answer only on a strobe, held between reads; unmapped reads zero
      s_next.rdata = 8'h00;
      if (bi == PAGE_GLOBAL) begin
        case (ri)
          GREG_MCR: s_next.rdata = {3'h0, s_reg.abort_all, 3'h0, s_reg.enh};
          GREG_BSEL: s_next.rdata = {2'h0, s_reg.dir};
          GREG_TXIF: s_next.rdata = {2'h0, s_reg.txif};
          GREG_TXIE: s_next.rdata = {2'h0, s_reg.txie};
          GREG_MISC: s_next.rdata = {5'h00, s_reg.rxie, s_reg.buserr_ie, s_reg.buserr};
          default: s_next.rdata = 8'h00;
        endcase
      end else if (int'(bi) < NBUF && ri <= REG_LAST) begin
        s_next.rdata = s_reg.mem[bi][ri];
      end
    end
    // Interrupt level from the next flags so it lines up with them
    s_next.irq = |(s_next.txif & s_next.txie) | (s_next.buserr & s_next.buserr_ie); // [RQ7] [RQ8]
    for (int i = 0; i < NBUF; i++) begin // [RQ17]
      if (s_next.rxie && !s_next.dir[i] && s_next.mem[i][REG_CTRL][CTL_FULL]) s_next.irq = 1'b1;
    end
  end

  // State register; all buffers come up as receive buffers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0; // [RQ23]
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.rdata = s_reg.rdata;
  assign bus.rd_valid = s_reg.rd_valid;
  assign bus.irq = s_reg.irq;
  assign tx_start = s_reg.tx_start;
  assign tx_idx = s_reg.tx_idx;
  assign tx_frame = s_reg.tx_frame;
endmodule : cmbc_dev

// *** src/cmbc_pkg.sv ***
// Shared constants and types for the CAN message buffer control block
package cmbc_pkg;
  // Buffer geometry
  localparam int NBUF = 6; // Programmable buffers
  localparam int NREG = 15; // Registers per buffer
  localparam int FRAME_BYTES = 13; // Identifier, length and data bytes
  localparam int FRAME_W = FRAME_BYTES * 8;
  // Register index inside a buffer (address bits 3:0)
  localparam logic [3:0] REG_CTRL = 4'h0; // Buffer control
  localparam logic [3:0] REG_STD_IDENT_HIGH = 4'h1; // std_ident_high
  localparam logic [3:0] REG_STD_IDENT_LOW = 4'h2; // std_ident_low
  localparam logic [3:0] REG_EXT_IDENT_HIGH = 4'h3; // ext_ident_high
  localparam logic [3:0] REG_EXT_IDENT_LOW = 4'h4; // ext_ident_low
  localparam logic [3:0] REG_DLC = 4'h5; // Length
  localparam logic [3:0] REG_RXSTAT = 4'he; // Receive status (remote flag)
  localparam logic [3:0] REG_LAST = 4'he; // Highest valid index
  // Buffer select (address bits 6:4); this value selects the global page
  localparam logic [2:0] PAGE_GLOBAL = 3'h7;
  // Global register index
  localparam logic [3:0] GREG_MCR = 4'h0; // module_control_register
  localparam logic [3:0] GREG_BSEL = 4'h1; // buffer_select_register
  localparam logic [3:0] GREG_TXIF = 4'h2; // transmit_done_irq_flag, write 1 to clear
  localparam logic [3:0] GREG_TXIE = 4'h3; // transmit_done_irq_enable
  localparam logic [3:0] GREG_MISC = 4'h4; // Bus error flag and enables
  // Transmit view of the control byte
  localparam int CTL_PRI = 0; // transmit_priority_field, 2 bits
  localparam int CTL_AUTO = 2; // auto_reply_enable
  localparam int CTL_SEND = 3; // send_request
  localparam int CTL_TRANSMIT_ERROR_FLAG = 4; // transmit_error_flag
  localparam int CTL_ARBL = 5; // arbitration_lost_flag
  localparam int CTL_ABORT = 6; // abort_done_flag
  // Receive view of the control byte
  localparam int CTL_HIT = 0; // filter_hit_index, 5 bits
  localparam int CTL_RXM = 5; // receive_mode_select, 2 bits
  localparam int CTL_FULL = 7; // receive_full_flag
  // Other fields
  localparam int STD_IDENT_LOW_EXT = 3; // extended_frame_flag in std_ident_low
  localparam int RXST_RTR = 0; // Remote frame received
  localparam int MCR_ENH = 0; // Enhanced mode select
  localparam int MCR_ABORT_ALL = 4; // abort_all_request
  localparam int MISC_BUSERR = 0; // bus_error_irq_flag, write 1 to clear
  localparam int MISC_BUSERR_IE = 1; // Bus error irq enable
  localparam int MISC_RXIE = 2; // Receive irq enable
  // Receive modes
  localparam logic [1:0] RXM_FILTERED = 2'h0;
  localparam logic [1:0] RXM_STD_ONLY = 2'h1;
  localparam logic [1:0] RXM_EXT_ONLY = 2'h2;
  localparam logic [1:0] RXM_ANY = 2'h3;
  // Reset value of every register byte
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Host command codes
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ABORT = 2'h2;
  localparam logic [1:0] OP_ABORT_ALL = 2'h3;
  // Frame contents, byte 0 is std_ident_high
  typedef logic [FRAME_BYTES-1:0][7:0] cmbc_frame_t;
endpackage : cmbc_pkg

// *** src/cmbc_if.sv ***
// Register access path between firmware side and the buffer controller
`timescale 1ns/1ps
interface cmbc_if;
  logic wr_en; // One-cycle write strobe
  logic rd_en; // One-cycle read strobe
  logic [7:0] addr; // Bits 6:4 page, 3:0 register
  logic [7:0] wdata; // Write data
  logic [7:0] rdata; // Read data, valid with rd_valid
  logic rd_valid; // Read answer, one cycle after rd_en
  logic irq; // Combined interrupt level
  modport dev (input wr_en, input rd_en, input addr, input wdata,
    output rdata, output rd_valid, output irq);
  modport host (output wr_en, output rd_en, output addr, output wdata,
    input rdata, input rd_valid, input irq);
endinterface : cmbc_if

// *** src/cmbc_prio_pick.sv ***
// Transmit arbiter: highest priority ready buffer, ties to highest number
`timescale 1ns/1ps
module cmbc_prio_pick
  import cmbc_pkg::*;
(
  input wire logic [NBUF-1:0] ready,
  input wire logic [NBUF-1:0][1:0] prio,
  output logic valid,
  output logic [2:0] idx
);
  logic [1:0] best; // Priority of current winner

  // Ascending scan with >= lets a later, higher numbered buffer win a tie
  always_comb begin
    valid = 1'b0;
    idx = 3'h0;
    best = 2'h0;
    for (int i = 0; i < NBUF; i++) begin
      if (ready[i] && (!valid || prio[i] >= best)) begin // [RQ14] [RQ15]
        valid = 1'b1;
        idx = 3'(i);
        best = prio[i];
      end
    end
  end
endmodule : cmbc_prio_pick

// *** src/cmbc_host.sv ***
// Firmware-side agent: issues register commands, guards writes and aborts
`timescale 1ns/1ps
module cmbc_host
  import cmbc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  cmbc_if.host bus,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic done,
  output logic [7:0] done_data,
  output logic refused,
  output logic irq
);
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_END} cmbc_host_st_t;

  typedef struct packed {
    cmbc_host_st_t st;
    logic [1:0] op;
    logic [7:0] addr; // Target of the final access
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic ready;
    logic done;
    logic [7:0] done_data;
    logic refused;
    logic irq;
  } cmbc_host_state_t;

  cmbc_host_state_t h_reg;
  cmbc_host_state_t h_next;

  // Command sequencing: reads of control precede guarded writes and buffer aborts, a read of MCR precedes abort-all
  always_comb begin
    h_next = h_reg;
    h_next.wr_en = 1'b0;
    h_next.rd_en = 1'b0;
    h_next.done = 1'b0;
    h_next.irq = bus.irq;
    case (h_reg.st)
      H_IDLE: begin
        h_next.ready = 1'b1;
        if (cmd_valid && h_reg.ready) begin
          h_next.ready = 1'b0;
          h_next.refused = 1'b0;
          h_next.op = cmd_op;
          h_next.addr = cmd_addr;
          h_next.wdata = cmd_wdata;
          if (cmd_op == OP_WRITE
              && (cmd_addr[6:4] == PAGE_GLOBAL || cmd_addr[3:0] == REG_CTRL)) begin
            // Control and global writes need no check
            h_next.wr_en = 1'b1;
            h_next.bus_addr = cmd_addr;
            h_next.bus_wdata = cmd_wdata;
            h_next.st = H_END;
          end else begin
            h_next.rd_en = 1'b1;
            h_next.st = H_WAIT;
            case (cmd_op)
              OP_READ: h_next.bus_addr = cmd_addr;
              OP_ABORT_ALL: h_next.bus_addr = {1'b0, PAGE_GLOBAL, GREG_MCR};
              default: h_next.bus_addr = {cmd_addr[7:4], REG_CTRL};
            endcase
          end
        end
      end
      H_WAIT: begin
        if (bus.rd_valid) begin
          h_next.st = H_END;
          h_next.done_data = bus.rdata;
          case (h_reg.op)
            OP_WRITE: begin
              if (bus.rdata[CTL_SEND]) begin
                h_next.refused = 1'b1; // [RQ4]
              end else begin
                h_next.wr_en = 1'b1; // [RQ4]
                h_next.bus_addr = h_reg.addr;
                h_next.bus_wdata = h_reg.wdata;
              end
            end
            OP_ABORT: begin
              h_next.wr_en = 1'b1;
              h_next.bus_wdata = bus.rdata & ~(8'h01 << CTL_SEND); // [RQ9]
            end
            OP_ABORT_ALL: begin
              h_next.wr_en = 1'b1;
              h_next.bus_wdata = bus.rdata | (8'h01 << MCR_ABORT_ALL); // [RQ10]
            end
            default: ;
          endcase
        end
      end
      H_END: begin
        h_next.done = 1'b1;
        h_next.st = H_IDLE;
      end
      default: h_next.st = H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end

  assign bus.wr_en = h_reg.wr_en;
  assign bus.rd_en = h_reg.rd_en;
  assign bus.addr = h_reg.bus_addr;
  assign bus.wdata = h_reg.bus_wdata;
  assign cmd_ready = h_reg.ready;
  assign done = h_reg.done;
  assign done_data = h_reg.done_data;
  assign refused = h_reg.refused;
  assign irq = h_reg.irq;
endmodule : cmbc_host

// *** bench/cmbc_bus_sva.sv ***
// Checker for the register path between the host agent and the buffer controller
`timescale 1ns/1ps
module cmbc_bus_sva
  import cmbc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rd_valid,
  input wire logic irq
);
  logic bsel_wr_reg; // Direction register written since reset
  logic irq_en_reg; // Some interrupt enable written nonzero since reset

  // Track writes that may legally change direction bits or open the interrupt path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bsel_wr_reg <= 1'b0;
      irq_en_reg <= 1'b0;
    end else if (wr_en) begin
      if (addr[6:0] == {PAGE_GLOBAL, GREG_BSEL}) bsel_wr_reg <= 1'b1;
      if (addr[6:0] == {PAGE_GLOBAL, GREG_TXIE} && wdata != 8'h00) irq_en_reg <= 1'b1;
      if (addr[6:0] == {PAGE_GLOBAL, GREG_MISC} && wdata[2:1] != 2'h0) irq_en_reg <= 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  rd_answer_a: assert property (rd_en |=> rd_valid)
    else $error("read strobe got no answer");
  rd_cause_a: assert property (rd_valid |-> $past(rd_en))
    else $error("read answer without a strobe");
  wr_single_a: assert property (wr_en |=> !wr_en)
    else $error("write strobe longer than one cycle");
  rd_single_a: assert property (rd_en |=> !rd_en)
    else $error("read strobe longer than one cycle");
  unmapped_zero_a: assert property (rd_en && (addr[6:4] == 3'h6 || addr[3:0] == 4'hf)
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_en |=> $stable(rdata))
    else $error("read data moved without a read");
  dir_reset_a: assert property (
    rd_en && addr[6:0] == {PAGE_GLOBAL, GREG_BSEL} && !bsel_wr_reg |=> rdata == 8'h00)
    else $error("buffers not in receive direction");
  irq_quiet_a: assert property (!irq_en_reg |-> !irq)
    else $error("interrupt with every enable clear");

  // Main scenarios reached
  cover property (rd_en ##1 rd_valid);
  cover property (wr_en && addr[6:0] == {PAGE_GLOBAL, GREG_MCR} && wdata[MCR_ABORT_ALL]);
  cover property ($rose(irq));
endmodule : cmbc_bus_sva

// *** bench/can_message_buffer_control_test.sv ***
// Bench: host agent and buffer controller joined over the register path
`timescale 1ns/1ps
module can_message_buffer_control_test
  import cmbc_pkg::*;
;
  // Receive mode cases: mode, ext, rtr, err, match, expect load
  localparam logic [6:0] MODE_TAB [7] = '{7'h03, 7'h00, 7'h32, 7'h23, 7'h53, 7'h42, 7'h65};
  logic clk, arst_n, cmd_valid, cmd_ready, done, refused, irq, tx_start;
  logic bus_idle, tx_ok, tx_arb_lost, tx_error, rx_valid, rx_ext, rx_rtr, rx_error;
  logic rx_match, rx_filter_ext, rx_mask_ext_en;
  logic [1:0] cmd_op;
  logic [2:0] rx_target, tx_idx;
  logic [4:0] rx_hit;
  logic [7:0] cmd_addr, cmd_wdata, done_data, rdv;
  cmbc_frame_t rx_frame, tx_frame;
  int bad_count, num_checks, waited;
  cmbc_if bus_if ();
  cmbc_host cmbc_host_i (.clk(clk), .arst_n(arst_n), .bus(bus_if), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .done(done), .done_data(done_data), .refused(refused), .irq(irq));
  cmbc_dev cmbc_dev_i (.clk(clk), .arst_n(arst_n), .bus(bus_if), .bus_idle(bus_idle),
    .tx_ok(tx_ok), .tx_arb_lost(tx_arb_lost), .tx_error(tx_error), .rx_valid(rx_valid),
    .rx_target(rx_target), .rx_frame(rx_frame), .rx_ext(rx_ext), .rx_rtr(rx_rtr),
    .rx_error(rx_error), .rx_match(rx_match), .rx_filter_ext(rx_filter_ext),
    .rx_mask_ext_en(rx_mask_ext_en), .rx_hit(rx_hit), .tx_start(tx_start), .tx_idx(tx_idx),
    .tx_frame(tx_frame));
  cmbc_bus_sva cmbc_bus_sva_i (.clk(clk), .arst_n(arst_n), .wr_en(bus_if.wr_en),
    .rd_en(bus_if.rd_en), .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
    .rd_valid(bus_if.rd_valid), .irq(bus_if.irq));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic test_done();
    $display("Totals: %0d checks, %0d mismatches", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Sample outputs at the falling edge, away from the launching edge; bounded
  task automatic step();
    @(negedge clk);
    waited++;
    if (waited > 500) begin
      bad_count++;
      $display("MISMATCH t=%0t wait limit reached", $time);
      test_done();
    end
  endtask : step

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // One host command: valid held until the edge where ready takes it
  task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
    waited = 0;
    do step(); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    waited = 0;
    do step(); while (done !== 1'b1);
    rdv = done_data;
  endtask : cmd

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cmd(OP_READ, a, 8'h00);
    chk(rdv, exp, $sformatf("read %h", a));
  endtask : rd

  // Free the bus and expect the arbiter to launch the given buffer
  task automatic start(input logic [2:0] idx);
    @(posedge clk);
    bus_idle <= 1'b1;
    waited = 0;
    do step(); while (tx_start !== 1'b1);
    chk({5'h00, tx_idx}, {5'h00, idx}, "transmit pick");
    @(posedge clk);
    bus_idle <= 1'b0;
  endtask : start

  // Outcome pulse of the frame on the bus: ok, arbitration lost, error
  task automatic outc(input logic [2:0] v);
    @(posedge clk);
    {tx_ok, tx_arb_lost, tx_error} <= v;
    @(posedge clk);
    {tx_ok, tx_arb_lost, tx_error} <= 3'h0;
  endtask : outc

  // Frame from the assembly side; f holds ext, rtr, err, match
  task automatic rxf(input logic [2:0] t, input logic [3:0] f, input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_target <= t;
    rx_frame <= {FRAME_BYTES{b}};
    {rx_ext, rx_rtr, rx_error, rx_match} <= f;
    rx_filter_ext <= f[3];
    rx_mask_ext_en <= f[3];
    rx_hit <= b[4:0];
    @(posedge clk);
    rx_valid <= 1'b0;
  endtask : rxf

  // Address is page in the upper nibble, register in the lower
  initial begin
    {arst_n, cmd_valid, bus_idle, tx_ok, tx_arb_lost, tx_error, rx_valid} = 7'h00;
    {rx_ext, rx_rtr, rx_error, rx_match, rx_filter_ext, rx_mask_ext_en} = 6'h00;
    {cmd_op, rx_target, rx_hit, cmd_addr, cmd_wdata} = 26'h000_0000;
    rx_frame = '0;
    bad_count = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h71, 8'h00);
    rd(8'h00, 8'h00);
    rd(8'h6f, 8'h00);
    cmd(OP_WRITE, 8'h71, 8'h27);
    cmd(OP_WRITE, 8'h00, 8'h0b);
    cmd(OP_WRITE, 8'h10, 8'h09);
    cmd(OP_WRITE, 8'h20, 8'h0b);
    start(3'h2);
    outc(3'h4);
    rd(8'h20, 8'h03);
    rd(8'h72, 8'h04);
    start(3'h0);
    outc(3'h2);
    rd(8'h00, 8'h2b);
    start(3'h0);
    outc(3'h1);
    rd(8'h00, 8'h3b);
    rd(8'h74, 8'h01);
    $display("Test transmit finished");
    cmd(OP_WRITE, 8'h11, 8'haa);
    chk({7'h00, refused}, 8'h01, "write refused");
    rd(8'h11, 8'h00);
    cmd(OP_WRITE, 8'h10, 8'h0a);
    rd(8'h10, 8'h09);
    cmd(OP_ABORT, 8'h00, 8'h00);
    rd(8'h00, 8'h73);
    cmd(OP_WRITE, 8'h00, 8'h0b);
    rd(8'h00, 8'h0b);
    cmd(OP_WRITE, 8'h20, 8'h0b);
    start(3'h2);
    cmd(OP_ABORT, 8'h20, 8'h00);
    outc(3'h4);
    rd(8'h20, 8'h03);
    start(3'h0);
    cmd(OP_ABORT_ALL, 8'h70, 8'h10);
    outc(3'h2);
    rd(8'h00, 8'h63);
    rd(8'h10, 8'h41);
    rd(8'h70, 8'h00);
    $display("Test abort finished");
    cmd(OP_WRITE, 8'h74, 8'h04);
    rxf(3'h3, 4'hd, 8'h55);
    rd(8'h30, 8'h85);
    rd(8'h32, 8'h5d);
    rd(8'h3d, 8'h55);
    rd(8'h3e, 8'h01);
    chk({7'h00, irq}, 8'h01, "receive irq");
    rxf(3'h3, 4'hd, 8'h52);
    rd(8'h3d, 8'h55);
    // Each case clears the full flag by rewriting the mode
    for (int i = 0; i < 7; i++) begin
      cmd(OP_WRITE, 8'h30, {MODE_TAB[i][6:5], 6'h00} >> 1);
      rxf(3'h3, MODE_TAB[i][4:1], {4'h5, MODE_TAB[i][4], 3'h1});
      cmd(OP_READ, 8'h30, 8'h00);
      chk({7'h00, rdv[7]}, {7'h00, MODE_TAB[i][0]}, "receive mode");
    end
    cmd(OP_WRITE, 8'h70, 8'h01);
    cmd(OP_WRITE, 8'h30, 8'h00);
    rxf(3'h3, 4'h1, 8'h5d);
    rd(8'h30, 8'h9d);
    rd(8'h32, 8'h55);
    cmd(OP_WRITE, 8'h51, 8'h3c);
    chk({7'h00, refused}, 8'h00, "write taken");
    cmd(OP_WRITE, 8'h50, 8'h04);
    rxf(3'h5, 4'h1, 8'h51);
    rd(8'h51, 8'h3c);
    rxf(3'h5, 4'h5, 8'h51);
    rd(8'h50, 8'h0c);
    start(3'h5);
    chk(tx_frame[0], 8'h3c, "reply byte");
    outc(3'h4);
    rd(8'h72, 8'h24);
    $display("Test receive finished");
    test_done();
  end
endmodule : can_message_buffer_control_test
